// ### verif/bbc_host.sv
`timescale 1ns/1ps
module bbc_host (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // Bus idle at time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // Write: address and data offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic pa, pw;
        {pa, pw} = 2'b11;
        @(posedge aclk);
        {awaddr, wdata, wstrb} <= {a, v, 4'hf};
        {awvalid, wvalid, bready} <= 3'b111;
        while (pa | pw) begin
            @(posedge aclk);
            if (awready) pa = 0;
            if (wready) pw = 0;
            {awvalid, wvalid} <= {pa, pw};
        end
        while (!bvalid) @(posedge aclk);
        r = bresp;
        bready <= 0;
    endtask : wr
    // Read: hold request until taken, answer taken with rready high
    task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        @(posedge aclk);
        while (!arready) @(posedge aclk);
        arvalid <= 0;
        @(posedge aclk);
        while (!rvalid) @(posedge aclk);
        {v, r} = {rdata, rresp};
        rready <= 0;
    endtask : rd
endmodule : bbc_host

// ### verif/bit_branch_call_clear_exec_tb.sv
`timescale 1ns/1ps
module bit_branch_call_clear_exec_tb;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, busy;
    int fails = 0;
    int check_count = 0;
    int bc = 0;
    // Flags, opcode, busy cycles, resulting PC
    logic [31:0] bt [4][4] = '{'{32'h04, 32'he480, 4, 32'h1002},
        '{32'h08, 32'he480, 8, 32'h0f02}, '{32'h08, 32'he07f, 4, 32'h1002},
        '{32'h04, 32'he07f, 8, 32'h1100}};
    // 40 MHz clock
    always #12.5 aclk = ~aclk;
    // Busy cycles seen at rising edges
    always @(posedge aclk) if (busy) bc <= bc + 1;
    bbc_core DUT (.*);
    bbc_host HOST (.*);
    task chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task w(input logic [7:0] a, input logic [31:0] v);
        HOST.wr(a, v, r);
        chk(r, 32'h0); // Write accepted with okay response
    endtask : w
    task rd(input logic [7:0] a, input logic [31:0] e);
        HOST.rd(a, d, r);
        chk(d, e);
    endtask : rd
    // Issue one instruction, wait for idle, compare busy length
    task run(input logic [31:0] i, input logic [31:0] n);
        int b0;
        b0 = bc;
        w(8'h00, i);
        @(negedge aclk);
        while (busy) @(negedge aclk);
        chk(bc - b0, n);
    endtask : run
    task conclude;
        if (fails == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    // Hang guard
    initial begin
        #(10000 * 25);
        fails++;
        conclude;
    end
    // Instruction sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        repeat (600) @(posedge aclk);
        run(32'h0004, 4);
        HOST.rd(8'h18, d, r);
        chk(d & 32'h1c03, 32'h3);
        w(8'h24, 32'h10);
        w(8'h28, 32'h75);
        w(8'h0c, 32'h1b);
        run(32'h7810, 4);
        rd(8'h28, 32'h65);
        rd(8'h0c, 32'h1b);
        w(8'h10, 32'h3);
        w(8'h24, 32'h310);
        run(32'h6b10, 4);
        rd(8'h28, 32'h0);
        rd(8'h0c, 32'h1f);
        w(8'h24, 32'h10);
        run(32'h1e10, 4);
        rd(8'h28, 32'h9a);
        run(32'h1c10, 4);
        rd(8'h08, 32'h65);
        rd(8'h0c, 32'h0b);
        for (int i = 0; i < 4; i++) begin
            w(8'h0c, bt[i][0]);
            w(8'h14, 32'h1000);
            run(bt[i][1], bt[i][2]);
            rd(8'h14, bt[i][3]);
            rd(8'h04, (bt[i][2] == 8) ? 32'h2 : 32'h0);
        end
        w(8'h08, 32'ha5);
        w(8'h0c, 32'h15);
        w(8'h14, 32'h2000);
        run(32'hfabced12, 8);
        rd(8'h14, 32'h157824);
        rd(8'h20, 32'h2004);
        rd(8'h1c, 32'h75a5);
        w(8'h08, 32'h11);
        run(32'hfabcec12, 8);
        rd(8'h1c, 32'h75a5);
        HOST.rd(8'h40, d, r);
        chk(r, 32'h2); // Unmapped read refused
        conclude;
    end
endmodule : bit_branch_call_clear_exec_tb

// ### verilog/bbc_consts.svh
`ifndef BBC_CONSTS_SVH
`define BBC_CONSTS_SVH
// Register byte offsets
`define BBC_OFF_INSTR 8'h00
`define BBC_OFF_STAT 8'h04
`define BBC_OFF_WREG 8'h08
`define BBC_OFF_FLAGS 8'h0c
`define BBC_OFF_BANK 8'h10
`define BBC_OFF_PC 8'h14
`define BBC_OFF_WDOG 8'h18
`define BBC_OFF_SHAD 8'h1c
`define BBC_OFF_HEAD 8'h20
`define BBC_OFF_MADDR 8'h24
`define BBC_OFF_MDATA 8'h28
// Flag bit positions
`define BBC_FL_C 0
`define BBC_FL_DC 1
`define BBC_FL_Z 2
`define BBC_FL_OV 3
`define BBC_FL_N 4
// Opcode patterns
`define BBC_OP_TOG 4'h7
`define BBC_OP_OVF_BR 8'he4
`define BBC_OP_NULL_BR 8'he0
`define BBC_OP_CALL 7'h76
`define BBC_OP_CALL2 4'hf
`define BBC_OP_CLR_FILE 7'h35
`define BBC_OP_DOG_CLR 16'h0004
`define BBC_OP_CMPL 6'h07
// Direct bank window split
`define BBC_ACC_SPLIT 8'h80
`define BBC_ACC_LO_BANK 4'h0
`define BBC_ACC_HI_BANK 4'hf
// Phases and answers
`define BBC_PH_READ 2'h1
`define BBC_PH_PROC 2'h2
`define BBC_PH_WRITE 2'h3
`define BBC_RESP_OK 2'h0
`define BBC_RESP_ERR 2'h2
// Reset values
`define BBC_PC_RST 21'h000000
`define BBC_FLAGS_RST 5'h00
`endif

// ### verilog/bbc_core.sv
`timescale 1ns/1ps
`include "bbc_consts.svh"
module bbc_core (
    input logic aclk,
    input logic aresetn,
    input logic [7:0] awaddr,
    input logic awvalid,
    output logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    input logic [7:0] araddr,
    input logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready,
    output logic busy
);
    localparam int DM_AW = 12;

    bbc_pkg::bbc_st_t st_ff, nxt_st;
    bbc_pkg::bbc_op_t op;
    logic [1:0] ph_ff, nxt_ph;
    logic [31:0] instr_ff, nxt_instr;
    logic [7:0] opnd_ff, nxt_opnd, res_ff, nxt_res;
    logic [7:0] w_ff, nxt_w, wsh_ff, nxt_wsh;
    logic [4:0] fl_ff, nxt_fl, fsh_ff, nxt_fsh;
    logic [3:0] bank_ff, nxt_bank, bsh_ff, nxt_bsh;
    logic [20:0] pc_ff, nxt_pc, head_ff, nxt_head;
    logic [11:0] maddr_ff, nxt_maddr;
    logic taken_ff, nxt_taken;
    logic aw_ok_ff, nxt_aw_ok, w_ok_ff, nxt_w_ok;
    logic [7:0] awa_ff, nxt_awa;
    logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd, rmux;
    logic [3:0] stb_ff, nxt_stb;
    logic bv_ff, nxt_bv, rv_ff, nxt_rv;
    logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
    logic [15:0] w1, w2;
    logic [7:0] fa, dm_rdata, dm_wdata, wd_cnt;
    logic acc_a, dst_d, shd_s, cond, q4, do_wr, wr_hit, rhit;
    logic [2:0] bsel, wd_post;
    logic [11:0] faddr, dm_addr;
    logic dm_wen, core_wen, wd_clr, wd_tlow, wd_slow;
    logic [20:0] br_tgt;

    function automatic logic [31:0] bbc_mrg(
        input logic [31:0] old,
        input logic [31:0] nw,
        input logic [3:0] stb
    );
        logic [31:0] m;
        m = {{8{stb[3]}}, {8{stb[2]}}, {8{stb[1]}}, {8{stb[0]}}};
        return (old & ~m) | (nw & m);
    endfunction : bbc_mrg

    // Instruction fields
    assign w1 = instr_ff[15:0];
    assign w2 = instr_ff[31:16];
    assign fa = w1[7:0];
    assign acc_a = w1[8];
    assign shd_s = w1[8];
    assign dst_d = w1[9];
    assign bsel = w1[11:9];

    // Opcode decode, combinational from the held instruction in every phase
    always_comb begin
        op = bbc_pkg::no_op;
        if (w1[15:12] == `BBC_OP_TOG) begin
            op = bbc_pkg::toggle_bit_op;
        end else if (w1[15:8] == `BBC_OP_OVF_BR) begin
            op = bbc_pkg::branch_on_overflow_op;
        end else if (w1[15:8] == `BBC_OP_NULL_BR) begin
            op = bbc_pkg::branch_on_null_op;
        end else if (w1[15:9] == `BBC_OP_CALL &&
                     w2[15:12] == `BBC_OP_CALL2) begin
            op = bbc_pkg::subroutine_call_op;
        end else if (w1[15:9] == `BBC_OP_CLR_FILE) begin
            op = bbc_pkg::clear_file_op;
        end else if (w1 == `BBC_OP_DOG_CLR) begin
            op = bbc_pkg::watchdog_clear_op;
        end else if (w1[15:10] == `BBC_OP_CMPL) begin
            op = bbc_pkg::complement_file_op;
        end
    end

    // Operand address: bank select or direct window
    assign faddr = acc_a ? {bank_ff, fa} :
        {(fa < `BBC_ACC_SPLIT) ? `BBC_ACC_LO_BANK : `BBC_ACC_HI_BANK, fa};

    // Branch condition and target
    assign cond = (op == bbc_pkg::branch_on_overflow_op &&
                   fl_ff[`BBC_FL_OV]) ||
                  (op == bbc_pkg::branch_on_null_op &&
                   fl_ff[`BBC_FL_Z]);
    assign br_tgt = pc_ff + 21'h2 + {{12{fa[7]}}, fa, 1'b0};

    // Data memory port sharing
    assign busy = st_ff != bbc_pkg::st_idle;
    assign q4 = st_ff == bbc_pkg::st_exec && ph_ff == `BBC_PH_WRITE;
    assign do_wr = aw_ok_ff && w_ok_ff && !bv_ff;
    assign core_wen = q4 && (op == bbc_pkg::toggle_bit_op ||
        op == bbc_pkg::clear_file_op ||
        (op == bbc_pkg::complement_file_op && dst_d));
    assign dm_addr = busy ? faddr : maddr_ff;
    assign dm_wen = core_wen ||
        (do_wr && !busy && awa_ff == `BBC_OFF_MDATA);
    assign dm_wdata = busy ? res_ff : wd_ff[7:0];
    assign wd_clr = st_ff == bbc_pkg::st_exec &&
        ph_ff == `BBC_PH_PROC &&
        op == bbc_pkg::watchdog_clear_op;

    bbc_dmem #(
        .AW(DM_AW)
    ) u_dmem (
        .aclk(aclk),
        .aresetn(aresetn),
        .addr(dm_addr),
        .wen(dm_wen),
        .wdata(dm_wdata),
        .rdata(dm_rdata)
    );

    bbc_wdog #(
        .CNT_W(8),
        .POST_W(3)
    ) u_wdog (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear_req(wd_clr),
        .watchdog_counter(wd_cnt),
        .postscaler(wd_post),
        .dog_expired_low(wd_tlow),
        .sleep_flag_low(wd_slow)
    );

    // Read mux and write decode
    always_comb begin
        rhit = 1'b1;
        unique case (araddr)
            `BBC_OFF_INSTR: rmux = instr_ff;
            `BBC_OFF_STAT: rmux = {30'h0, taken_ff, busy};
            `BBC_OFF_WREG: rmux = {24'h0, w_ff};
            `BBC_OFF_FLAGS: rmux = {27'h0, fl_ff};
            `BBC_OFF_BANK: rmux = {28'h0, bank_ff};
            `BBC_OFF_PC: rmux = {11'h0, pc_ff};
            `BBC_OFF_WDOG: rmux = {19'h0, wd_post, wd_cnt, wd_slow, wd_tlow};
            `BBC_OFF_SHAD: rmux = {15'h0, bsh_ff, fsh_ff, wsh_ff};
            `BBC_OFF_HEAD: rmux = {11'h0, head_ff};
            `BBC_OFF_MADDR: rmux = {20'h0, maddr_ff};
            `BBC_OFF_MDATA: begin
                rmux = {24'h0, dm_rdata};
                rhit = !busy;
            end
            default: begin
                rmux = 32'h0;
                rhit = 1'b0;
            end
        endcase
        wr_hit = awa_ff[1:0] == 2'h0 && awa_ff <= `BBC_OFF_MDATA;
    end

    // Bus channel handshakes
    assign awready = !aw_ok_ff && !bv_ff;
    assign wready = !w_ok_ff && !bv_ff;
    assign arready = !rv_ff;

    always_comb begin
        nxt_aw_ok = aw_ok_ff;
        nxt_w_ok = w_ok_ff;
        nxt_awa = awa_ff;
        nxt_wd = wd_ff;
        nxt_stb = stb_ff;
        nxt_bv = bv_ff;
        nxt_br = br_ff;
        nxt_rv = rv_ff;
        nxt_rd = rd_ff;
        nxt_rr = rr_ff;
        if (awvalid && awready) begin
            nxt_aw_ok = 1'b1;
            nxt_awa = awaddr;
        end
        if (wvalid && wready) begin
            nxt_w_ok = 1'b1;
            nxt_wd = wdata;
            nxt_stb = wstrb;
        end
        if (do_wr) begin
            nxt_aw_ok = 1'b0;
            nxt_w_ok = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = (wr_hit && !busy) ? `BBC_RESP_OK : `BBC_RESP_ERR;
        end
        if (bv_ff && bready) begin
            nxt_bv = 1'b0;
        end
        if (arvalid && arready) begin
            nxt_rv = 1'b1;
            nxt_rd = rhit ? rmux : 32'h0;
            nxt_rr = rhit ? `BBC_RESP_OK : `BBC_RESP_ERR;
        end
        if (rv_ff && rready) begin
            nxt_rv = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_ff <= 1'b0;
            w_ok_ff <= 1'b0;
            awa_ff <= 8'h00;
            wd_ff <= 32'h0;
            stb_ff <= 4'h0;
            bv_ff <= 1'b0;
            br_ff <= `BBC_RESP_OK;
            rv_ff <= 1'b0;
            rd_ff <= 32'h0;
            rr_ff <= `BBC_RESP_OK;
        end else begin
            aw_ok_ff <= nxt_aw_ok;
            w_ok_ff <= nxt_w_ok;
            awa_ff <= nxt_awa;
            wd_ff <= nxt_wd;
            stb_ff <= nxt_stb;
            bv_ff <= nxt_bv;
            br_ff <= nxt_br;
            rv_ff <= nxt_rv;
            rd_ff <= nxt_rd;
            rr_ff <= nxt_rr;
        end
    end

    assign bvalid = bv_ff;
    assign bresp = br_ff;
    assign rvalid = rv_ff;
    assign rdata = rd_ff;
    assign rresp = rr_ff;

    // Register writes while idle, then the four-phase sequence
    always_comb begin
        logic [31:0] t;
        t = 32'h0;
        nxt_st = st_ff;
        nxt_ph = busy ? ph_ff + 2'h1 : 2'h0;
        nxt_instr = instr_ff;
        nxt_opnd = opnd_ff;
        nxt_res = res_ff;
        nxt_w = w_ff;
        nxt_fl = fl_ff;
        nxt_bank = bank_ff;
        nxt_pc = pc_ff;
        nxt_head = head_ff;
        nxt_wsh = wsh_ff;
        nxt_fsh = fsh_ff;
        nxt_bsh = bsh_ff;
        nxt_maddr = maddr_ff;
        nxt_taken = taken_ff;
        unique case (st_ff)
            bbc_pkg::st_idle: begin
                if (do_wr) begin
                    unique case (awa_ff)
                        `BBC_OFF_INSTR: begin
                            nxt_instr = bbc_mrg(instr_ff, wd_ff, stb_ff);
                            nxt_st = bbc_pkg::st_exec;
                        end
                        `BBC_OFF_WREG: begin
                            t = bbc_mrg({24'h0, w_ff}, wd_ff, stb_ff);
                            nxt_w = t[7:0];
                        end
                        `BBC_OFF_FLAGS: begin
                            t = bbc_mrg({27'h0, fl_ff}, wd_ff, stb_ff);
                            nxt_fl = t[4:0];
                        end
                        `BBC_OFF_BANK: begin
                            t = bbc_mrg({28'h0, bank_ff}, wd_ff, stb_ff);
                            nxt_bank = t[3:0];
                        end
                        `BBC_OFF_PC: begin
                            t = bbc_mrg({11'h0, pc_ff}, wd_ff, stb_ff);
                            nxt_pc = {t[20:1], 1'b0};
                        end
                        `BBC_OFF_MADDR: begin
                            t = bbc_mrg({20'h0, maddr_ff}, wd_ff, stb_ff);
                            nxt_maddr = t[11:0];
                        end
                        default: ;
                    endcase
                end
            end
            bbc_pkg::st_exec: begin
                unique case (ph_ff)
                    `BBC_PH_READ: nxt_opnd = dm_rdata;
                    `BBC_PH_PROC: begin
                        unique case (op)
                            bbc_pkg::toggle_bit_op:
                                nxt_res = opnd_ff ^ (8'h01 << bsel);
                            bbc_pkg::clear_file_op:
                                nxt_res = 8'h00;
                            bbc_pkg::complement_file_op:
                                nxt_res = ~opnd_ff;
                            bbc_pkg::subroutine_call_op:
                                nxt_head = pc_ff + 21'h4;
                            default: ;
                        endcase
                    end
                    `BBC_PH_WRITE: begin
                        nxt_pc = pc_ff + 21'h2;
                        nxt_taken = 1'b0;
                        nxt_st = bbc_pkg::st_idle;
                        unique case (op)
                            bbc_pkg::complement_file_op: begin
                                nxt_fl[`BBC_FL_Z] = res_ff == 8'h00;
                                nxt_fl[`BBC_FL_N] = res_ff[7];
                                if (!dst_d) begin
                                    nxt_w = res_ff;
                                end
                            end
                            bbc_pkg::clear_file_op:
                                nxt_fl[`BBC_FL_Z] = 1'b1;
                            bbc_pkg::branch_on_overflow_op,
                            bbc_pkg::branch_on_null_op: begin
                                if (cond) begin
                                    nxt_pc = br_tgt;
                                    nxt_taken = 1'b1;
                                    nxt_st = bbc_pkg::st_nop;
                                end
                            end
                            bbc_pkg::subroutine_call_op: begin
                                nxt_pc = {w2[11:0], fa, 1'b0};
                                nxt_st = bbc_pkg::st_nop;
                                if (shd_s) begin
                                    nxt_wsh = w_ff;
                                    nxt_fsh = fl_ff;
                                    nxt_bsh = bank_ff;
                                end
                            end
                            default: ;
                        endcase
                    end
                    default: ;
                endcase
            end
            bbc_pkg::st_nop: begin
                if (ph_ff == `BBC_PH_WRITE) begin
                    nxt_st = bbc_pkg::st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= bbc_pkg::st_idle;
            ph_ff <= 2'h0;
            instr_ff <= 32'h0;
            opnd_ff <= 8'h00;
            res_ff <= 8'h00;
            w_ff <= 8'h00;
            fl_ff <= `BBC_FLAGS_RST;
            bank_ff <= 4'h0;
            pc_ff <= `BBC_PC_RST;
            head_ff <= `BBC_PC_RST;
            wsh_ff <= 8'h00;
            fsh_ff <= `BBC_FLAGS_RST;
            bsh_ff <= 4'h0;
            maddr_ff <= 12'h000;
            taken_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            ph_ff <= nxt_ph;
            instr_ff <= nxt_instr;
            opnd_ff <= nxt_opnd;
            res_ff <= nxt_res;
            w_ff <= nxt_w;
            fl_ff <= nxt_fl;
            bank_ff <= nxt_bank;
            pc_ff <= nxt_pc;
            head_ff <= nxt_head;
            wsh_ff <= nxt_wsh;
            fsh_ff <= nxt_fsh;
            bsh_ff <= nxt_bsh;
            maddr_ff <= nxt_maddr;
            taken_ff <= nxt_taken;
        end
    end

    // Checks on the execution sequence
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_idle_cycle;
        st_ff == bbc_pkg::st_nop [*4];
    endsequence

    property p_toggle;
        q4 && op == bbc_pkg::toggle_bit_op |-> dm_wen &&
            dm_wdata == (opnd_ff ^ (8'h01 << bsel)) ##1 $stable(fl_ff);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("bit toggle wrong");

    property p_access;
        busy && !acc_a |-> dm_addr[11:8] == {4{fa[7]}};
    endproperty
    a_access: assert property (p_access)
        else $error("direct bank window wrong");

    property p_untaken;
        q4 && (op == bbc_pkg::branch_on_overflow_op ||
            op == bbc_pkg::branch_on_null_op) && !cond |=>
            pc_ff == $past(pc_ff) + 21'h2 && st_ff == bbc_pkg::st_idle;
    endproperty
    a_untaken: assert property (p_untaken)
        else $error("untaken branch wrong");

    property p_taken_two;
        q4 && cond |=> s_idle_cycle ##1 st_ff == bbc_pkg::st_idle;
    endproperty
    a_taken_two: assert property (p_taken_two)
        else $error("taken branch not two cycles");

    property p_target;
        q4 && cond |=> pc_ff == $past(pc_ff) + 21'h2 +
            {{12{$past(fa[7])}}, $past(fa), 1'b0};
    endproperty
    a_target: assert property (p_target)
        else $error("branch target wrong");

    property p_call;
        q4 && op == bbc_pkg::subroutine_call_op |=>
            (pc_ff == {$past(w2[11:0]), $past(fa), 1'b0} &&
            head_ff == $past(pc_ff) + 21'h4) ##0 s_idle_cycle ##1
            st_ff == bbc_pkg::st_idle;
    endproperty
    a_call: assert property (p_call)
        else $error("call target, push or timing wrong");

    property p_shadow;
        q4 && op == bbc_pkg::subroutine_call_op && !shd_s |=>
            $stable(wsh_ff) && $stable(fsh_ff) && $stable(bsh_ff);
    endproperty
    a_shadow: assert property (p_shadow)
        else $error("shadows changed without shadow bit");

    property p_clear;
        q4 && op == bbc_pkg::clear_file_op |-> dm_wen &&
            dm_wdata == 8'h00 ##1 fl_ff[`BBC_FL_Z];
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear op wrong");

    property p_comp_w;
        q4 && op == bbc_pkg::complement_file_op && !dst_d |-> !dm_wen
            ##1 w_ff == ~$past(opnd_ff) &&
            fl_ff[`BBC_FL_N] == w_ff[7];
    endproperty
    a_comp_w: assert property (p_comp_w)
        else $error("complement to accumulator wrong");

    property p_phase;
        st_ff == bbc_pkg::st_exec && ph_ff == 2'h0 |=>
            ph_ff == `BBC_PH_READ ##1 opnd_ff == $past(dm_rdata);
    endproperty
    a_phase: assert property (p_phase)
        else $error("operand not read in second phase");
endmodule : bbc_core

// ### verilog/bbc_dmem.sv
`timescale 1ns/1ps
module bbc_dmem #(
    parameter int AW = 12
) (
    input logic aclk,
    input logic aresetn,
    input logic [AW-1:0] addr,
    input logic wen,
    input logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:(1<<AW)-1];
    logic [7:0] rd_ff;

    if (AW < 1 || AW > 16) begin : g_chk
        $error("bbc_dmem: AW out of range");
    end

    // Synchronous write, registered read
    always_ff @(posedge aclk) begin
        if (wen) begin
            mem[addr] <= wdata;
        end
        if (!aresetn) begin
            rd_ff <= 8'h00;
        end else begin
            rd_ff <= mem[addr];
        end
    end
    assign rdata = rd_ff;
endmodule : bbc_dmem

// ### verilog/bbc_pkg.sv
package bbc_pkg;
    typedef enum logic [1:0] {st_idle, st_exec, st_nop} bbc_st_t;
    typedef enum logic [2:0] {
        no_op,
        toggle_bit_op,
        branch_on_overflow_op,
        branch_on_null_op,
        subroutine_call_op,
        clear_file_op,
        watchdog_clear_op,
        complement_file_op
    } bbc_op_t;
endpackage : bbc_pkg

// ### verilog/bbc_wdog.sv
`timescale 1ns/1ps
module bbc_wdog #(
    parameter int CNT_W = 8,
    parameter int POST_W = 3
) (
    input logic aclk,
    input logic aresetn,
    input logic clear_req,
    output logic [CNT_W-1:0] watchdog_counter,
    output logic [POST_W-1:0] postscaler,
    output logic dog_expired_low,
    output logic sleep_flag_low
);
    logic [CNT_W-1:0] cnt_ff, nxt_cnt;
    logic [POST_W-1:0] post_ff, nxt_post;
    logic tlow_ff, nxt_tlow, slow_ff, nxt_slow;

    if (CNT_W < 1 || POST_W < 1) begin : g_chk
        $error("bbc_wdog: widths must be positive");
    end

    // Count, timeout, clear wins
    always_comb begin
        nxt_cnt = cnt_ff + 1'b1;
        nxt_post = post_ff;
        nxt_tlow = tlow_ff;
        nxt_slow = slow_ff;
        if (&cnt_ff) begin
            nxt_post = post_ff + 1'b1;
            if (&post_ff) begin
                nxt_tlow = 1'b0;
            end
        end
        if (clear_req) begin
            nxt_cnt = '0;
            nxt_post = '0;
            nxt_tlow = 1'b1;
            nxt_slow = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= '0;
            post_ff <= '0;
            tlow_ff <= 1'b1;
            slow_ff <= 1'b1;
        end else begin
            cnt_ff <= nxt_cnt;
            post_ff <= nxt_post;
            tlow_ff <= nxt_tlow;
            slow_ff <= nxt_slow;
        end
    end

    assign watchdog_counter = cnt_ff;
    assign postscaler = post_ff;
    assign dog_expired_low = tlow_ff;
    assign sleep_flag_low = slow_ff;

    property p_wd_clear;
        @(posedge aclk) disable iff (!aresetn)
        clear_req |=> cnt_ff == '0 && post_ff == '0 && tlow_ff && slow_ff;
    endproperty
    a_wd_clear: assert property (p_wd_clear)
        else $error("watchdog clear did not take effect");
endmodule : bbc_wdog
